// file: hdl/tomc_map.vh
// constants for the timer output mode control block
// assumes an 8-bit register port with four registers at printed offsets
`ifndef TOMC_MAP_VH
`define TOMC_MAP_VH
// ==========================================================
// register offsets
`define TOMC_ADDR_W 20
`define TOMC_OFF_FUNC 20'hf0266
`define TOMC_OFF_ODIS 20'hf0267
`define TOMC_OFF_CUT 20'hf0268
`define TOMC_OFF_INIT 20'hf0269
// ==========================================================
// reset values
`define TOMC_RST_FUNC 8'h80
`define TOMC_RST_ODIS 8'hff
`define TOMC_RST_CUT 8'h00
`define TOMC_RST_INIT 8'h00
// ==========================================================
// field positions
`define TOMC_FUNC_DCPWM 7
`define TOMC_FUNC_EXTCLK 6
`define TOMC_FUNC_CPOL 3
`define TOMC_FUNC_NPOL 2
`define TOMC_FUNC_CMD_HI 1
`define TOMC_FUNC_CMD_LO 0
`define TOMC_CUT_PINEN 7
`define TOMC_CUT_FLAG 0
`define TOMC_FUNC_WMASK 8'hcf
`define TOMC_CUT_WMASK 8'h81
// ==========================================================
// combination modes and cutoff actions
`define TOMC_CMD_TIMER 2'h0
`define TOMC_CMD_RSYNC 2'h1
`define TOMC_CMD_CP_C1 2'h2
`define TOMC_CMD_CP_C0 2'h3
`define TOMC_CUTACT_NONE 2'h0
`define TOMC_CUTACT_HIZ 2'h1
`define TOMC_CUTACT_LOW 2'h2
`define TOMC_CUTACT_HIGH 2'h3
`endif

// file: hdl/tomc_pin_drive.v
// one timer output pin: cutoff and disable override of the waveform
// assumes wave input already carries polarity for the active mode
`timescale 1ns/100ps
`default_nettype none
`include "tomc_map.vh"
module tomc_pin_drive (
    // configuration
    input wire out_disable,
    input wire [1:0] cut_action,
    input wire cutoff,
    // waveform
    input wire wave,
    // pin
    output reg pin_o,
    output reg pin_oe
);
    // ==========================================================
    // pin resolution, cutoff beats waveform
    always @* begin
        pin_o = wave;
        pin_oe = ~out_disable;
        if (cutoff && !out_disable) begin
            case (cut_action)
                `TOMC_CUTACT_HIZ: begin
                    pin_o = 1'b0;
                    pin_oe = 1'b0;
                end
                `TOMC_CUTACT_LOW: pin_o = 1'b0;
                `TOMC_CUTACT_HIGH: pin_o = 1'b1;
                default: pin_o = wave;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: hdl/tomc_top.v
// mode and output control for a two-channel timer
// assumes counters elsewhere feed raw compare waveforms and run bits
`timescale 1ns/100ps
`default_nettype none
`include "tomc_map.vh"
module tomc_top #(
    parameter NPIN = 8
) (
    // clock and reset
    input wire REF_CLK,
    input wire RST,
    // register port
    input wire [`TOMC_ADDR_W-1:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    // counter side
    input wire COUNTER0_RUN,
    input wire COUNTER1_RUN,
    input wire [NPIN-1:0] PIN_PWM_SELECT,
    input wire [NPIN-1:0] RAW_WAVE,
    input wire [NPIN-1:0] PHASE_IS_COUNTER,
    input wire EXT_CLK_IN,
    input wire COUNTER0_MATCH_A,
    input wire COUNTER1_EVENT,
    // cutoff sources
    input wire CUTOFF_INTERRUPT_PIN_N,
    input wire EVENT_LINK_CUTOFF,
    // cutoff action per pin, two bits each
    input wire [2*NPIN-1:0] CUT_ACTION,
    // mode status to the counters
    output wire DUAL_COMPARE_PWM,
    output wire RESET_SYNC_PWM,
    output wire COMPLEMENTARY_PWM,
    output wire EXT_COUNT_CLOCK,
    output wire BUFFER_TRANSFER,
    output wire CUTOFF_ACTIVE,
    // pins
    output wire [NPIN-1:0] PIN_O,
    output wire [NPIN-1:0] PIN_OE
);
    // ==========================================================
    // register state
    reg [7:0] func_q;
    reg [7:0] odis_q;
    reg pinen_q;
    reg flag_q;
    reg [7:0] init_q;
    reg init_load_q;
    reg [NPIN-1:0] wave_q;
    wire [1:0] cmd;
    wire combo;
    wire dc_mode;
    wire stopped;

    // one decode used for both write and read paths
    function hit;
        input [`TOMC_ADDR_W-1:0] a;
        input [`TOMC_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    assign cmd = {func_q[`TOMC_FUNC_CMD_HI], func_q[`TOMC_FUNC_CMD_LO]};
    assign combo = (cmd != `TOMC_CMD_TIMER);
    assign dc_mode = !combo && !func_q[`TOMC_FUNC_DCPWM];
    assign stopped = !COUNTER0_RUN && !COUNTER1_RUN;

    // ==========================================================
    // register writes and cutoff flag
    always @(posedge REF_CLK) begin
        if (RST) begin
            func_q <= `TOMC_RST_FUNC;
            odis_q <= `TOMC_RST_ODIS;
            pinen_q <= 1'b0;
            flag_q <= 1'b0;
            init_q <= `TOMC_RST_INIT;
            init_load_q <= 1'b0;
        end else begin
            init_load_q <= WR && hit(ADDR, `TOMC_OFF_INIT);
            // mode change relies on software stopping both counters
            if (WR && hit(ADDR, `TOMC_OFF_FUNC))
                func_q <= WDATA & `TOMC_FUNC_WMASK;
            if (WR && hit(ADDR, `TOMC_OFF_ODIS))
                odis_q <= WDATA;
            if (WR && hit(ADDR, `TOMC_OFF_INIT))
                init_q <= WDATA;
            if (WR && hit(ADDR, `TOMC_OFF_CUT)) begin
                pinen_q <= WDATA[`TOMC_CUT_PINEN];
                // clearing only takes while stopped; writing 1 forces
                if (WDATA[`TOMC_CUT_FLAG])
                    flag_q <= 1'b1;
                else if (stopped)
                    flag_q <= 1'b0;
            end
            // hardware sources win over a clearing write
            if ((pinen_q && !CUTOFF_INTERRUPT_PIN_N) || EVENT_LINK_CUTOFF)
                flag_q <= 1'b1;
        end
    end

    // ==========================================================
    // read data, one cycle after the strobe
    always @(posedge REF_CLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            if (hit(ADDR, `TOMC_OFF_FUNC))
                RDATA <= func_q;
            else if (hit(ADDR, `TOMC_OFF_ODIS))
                RDATA <= odis_q;
            else if (hit(ADDR, `TOMC_OFF_CUT))
                RDATA <= {pinen_q, 6'h00, flag_q};
            else if (hit(ADDR, `TOMC_OFF_INIT))
                RDATA <= init_q;
            else
                RDATA <= 8'h00;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ==========================================================
    // waveform per pin: init write loads initial level while stopped (else holds), running gives counter wave
    genvar i;
    generate
        for (i = 0; i < NPIN; i = i + 1) begin : g_pin
            wire pol;
            wire pwm_fn;
            reg wave_d;
            // polarity bit picks initial level in combination modes
            assign pol = PHASE_IS_COUNTER[i] ?
                func_q[`TOMC_FUNC_CPOL] : func_q[`TOMC_FUNC_NPOL];
            assign pwm_fn = PIN_PWM_SELECT[i] && !combo;
            always @* begin
                wave_d = wave_q[i];
                if (init_load_q || !stopped) begin
                    if (combo) begin
                        // 0 gives high initial, low active
                        wave_d = stopped ? ~pol : (RAW_WAVE[i] ~^ pol);
                    end else if (!stopped) begin
                        wave_d = RAW_WAVE[i];
                    end else if (pwm_fn) begin
                        wave_d = init_q[i];
                    end else begin
                        wave_d = init_q[i];
                    end
                end
            end
            always @(posedge REF_CLK) begin
                if (RST)
                    wave_q[i] <= 1'b0;
                else
                    wave_q[i] <= wave_d;
            end
            tomc_pin_drive u_drive (
                .out_disable(odis_q[i]),
                .cut_action(CUT_ACTION[2*i+1:2*i]),
                .cutoff(flag_q),
                .wave(wave_q[i]),
                .pin_o(PIN_O[i]),
                .pin_oe(PIN_OE[i])
            );
        end
    endgenerate

    // ==========================================================
    // mode status outputs
    assign DUAL_COMPARE_PWM = dc_mode;
    assign RESET_SYNC_PWM = (cmd == `TOMC_CMD_RSYNC);
    assign COMPLEMENTARY_PWM = cmd[1];
    // external clock blocked in dual-compare pwm
    assign EXT_COUNT_CLOCK = func_q[`TOMC_FUNC_EXTCLK] && !dc_mode &&
        EXT_CLK_IN;
    // buffer transfer moment depends on complementary variant
    assign BUFFER_TRANSFER = (cmd == `TOMC_CMD_CP_C0) ? COUNTER0_MATCH_A :
        (cmd == `TOMC_CMD_CP_C1) ? COUNTER1_EVENT : 1'b0;
    assign CUTOFF_ACTIVE = flag_q;
endmodule
`default_nettype wire

// file: tb/tomc_load.sv
// load model on the timer pins: pull-up where the block lets go
// assumes one pad per pin and a resistor to the high rail
`timescale 1ns/100ps
`default_nettype none
module tomc_load #(parameter NPIN = 8) (
    // pins from the block
    input wire logic [NPIN-1:0] pin_o,
    input wire logic [NPIN-1:0] pin_oe,
    // resolved pad level
    output logic [NPIN-1:0] pad
);
    // released pins float up, so hi-z never reads as a stale level
    assign pad = (pin_o & pin_oe) | ~pin_oe;
endmodule
`default_nettype wire

// file: tb/tomc_top_sva.sv
// checker for the timer output mode control block
// assumes it is bound onto tomc_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "tomc_map.vh"
module tomc_top_sva #(parameter NPIN = 8) (
    // clock, reset and register port
    input wire logic REF_CLK, RST, WR, COUNTER0_RUN, COUNTER1_RUN,
    input wire logic [`TOMC_ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    // counter side and cutoff sources
    input wire logic EXT_CLK_IN, COUNTER0_MATCH_A, COUNTER1_EVENT,
    input wire logic CUTOFF_INTERRUPT_PIN_N, EVENT_LINK_CUTOFF,
    input wire logic [2*NPIN-1:0] CUT_ACTION,
    // outputs watched
    input wire logic DUAL_COMPARE_PWM, COMPLEMENTARY_PWM, EXT_COUNT_CLOCK,
    input wire logic RESET_SYNC_PWM, BUFFER_TRANSFER, CUTOFF_ACTIVE,
    input wire logic [NPIN-1:0] PIN_O, PIN_OE
);
    logic [7:0] odis_q;
    logic pin_en_q;
    logic clr;
    // ==========================================================
    // shadow of disable mask and cutoff pin enable
    always @(posedge REF_CLK) begin
        if (RST) begin
            odis_q <= `TOMC_RST_ODIS;
            pin_en_q <= 1'b0;
        end else if (WR && ADDR == `TOMC_OFF_ODIS) begin
            odis_q <= WDATA;
        end else if (WR && ADDR == `TOMC_OFF_CUT) begin
            pin_en_q <= WDATA[7];
        end
    end
    // legal clearing write; a hardware set in that cycle still wins
    assign clr = WR && ADDR == `TOMC_OFF_CUT && !WDATA[0]
        && !COUNTER0_RUN && !COUNTER1_RUN;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    chk_dual_only_plain: assert property (
        DUAL_COMPARE_PWM |-> !RESET_SYNC_PWM && !COMPLEMENTARY_PWM)
        else $error("dual compare beside combination mode");
    chk_ext_clock_gate: assert property (
        EXT_COUNT_CLOCK |-> EXT_CLK_IN && !DUAL_COMPARE_PWM)
        else $error("external count clock passed wrongly");
    chk_xfer_cause: assert property (
        !COUNTER0_MATCH_A && !COUNTER1_EVENT |-> !BUFFER_TRANSFER)
        else $error("buffer transfer without cause");
    chk_pin_cut_set: assert property (
        pin_en_q && !CUTOFF_INTERRUPT_PIN_N |=> CUTOFF_ACTIVE)
        else $error("cutoff pin did not set flag");
    chk_event_cut_set: assert property (
        EVENT_LINK_CUTOFF |=> CUTOFF_ACTIVE)
        else $error("event link did not set flag");
    chk_flag_sticky: assert property (
        CUTOFF_ACTIVE && !clr |=> $stable(CUTOFF_ACTIVE))
        else $error("cutoff flag dropped by itself");
    chk_disable_oe: assert property (
        !CUTOFF_ACTIVE |-> PIN_OE == ~odis_q)
        else $error("pin enable disagrees with mask");
    chk_cut_drive_level: assert property (
        CUTOFF_ACTIVE && CUT_ACTION[9] && !odis_q[4]
        |-> PIN_OE[4] && PIN_O[4] == CUT_ACTION[8])
        else $error("cutoff level wrong on pin 4");
endmodule
bind tomc_top tomc_top_sva #(.NPIN(NPIN)) i_sva (.REF_CLK(REF_CLK),
    .RST(RST), .WR(WR), .COUNTER0_RUN(COUNTER0_RUN), .ADDR(ADDR),
    .COUNTER1_RUN(COUNTER1_RUN), .WDATA(WDATA), .EXT_CLK_IN(EXT_CLK_IN),
    .COUNTER0_MATCH_A(COUNTER0_MATCH_A), .COUNTER1_EVENT(COUNTER1_EVENT),
    .CUTOFF_INTERRUPT_PIN_N(CUTOFF_INTERRUPT_PIN_N), .CUT_ACTION(CUT_ACTION),
    .EVENT_LINK_CUTOFF(EVENT_LINK_CUTOFF), .DUAL_COMPARE_PWM(DUAL_COMPARE_PWM),
    .COMPLEMENTARY_PWM(COMPLEMENTARY_PWM), .EXT_COUNT_CLOCK(EXT_COUNT_CLOCK),
    .RESET_SYNC_PWM(RESET_SYNC_PWM), .BUFFER_TRANSFER(BUFFER_TRANSFER),
    .CUTOFF_ACTIVE(CUTOFF_ACTIVE), .PIN_O(PIN_O), .PIN_OE(PIN_OE));
`default_nettype wire

// file: tb/tomc_top_tb.sv
// self-checking bench for the timer output mode control block
// assumes tomc_top with eight pins and the pull-up load model
`timescale 1ns/100ps
`default_nettype none
`include "tomc_map.vh"
module tomc_top_tb;
    logic clk = 0, rst = 1, wr = 0, rd = 0, run0 = 0, xclk = 1;
    logic m0 = 0, e1 = 0, pin_n = 1, evl = 0;
    logic [19:0] addr = 0;
    logic [7:0] wdata = 0, rdata, po, poe, pad;
    logic [15:0] cut_act = 16'h0600; // pin 4 low, pin 5 hi-z
    logic dc, rs, cp, xc, bt, ca;
    logic [31:0] rv = {`TOMC_RST_FUNC, `TOMC_RST_ODIS, 16'h0000};
    int n_mismatch = 0, n_tests = 0;
    tomc_top i_dut (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .COUNTER0_RUN(run0),
        .COUNTER1_RUN(1'b0), .PIN_PWM_SELECT(8'h00), .RAW_WAVE(8'h00),
        .PHASE_IS_COUNTER(8'h00), .EXT_CLK_IN(xclk), .COUNTER0_MATCH_A(m0),
        .COUNTER1_EVENT(e1), .CUTOFF_INTERRUPT_PIN_N(pin_n),
        .EVENT_LINK_CUTOFF(evl), .CUT_ACTION(cut_act), .DUAL_COMPARE_PWM(dc),
        .RESET_SYNC_PWM(rs), .COMPLEMENTARY_PWM(cp), .EXT_COUNT_CLOCK(xc),
        .BUFFER_TRANSFER(bt), .CUTOFF_ACTIVE(ca), .PIN_O(po), .PIN_OE(poe));
    tomc_load i_load (.pin_o(po), .pin_oe(poe), .pad(pad));
    // ==========================================================
    // clock, checks and bus tasks
    initial forever #5 clk = ~clk;
    task chk(input [7:0] s, input [7:0] e, input string n);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // each task starts at an edge, so strobes never change twice at once
    task wr_reg(input [19:0] a, input [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task rd_reg(input [19:0] a, input [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata, e, "rdata");
    endtask
    task complete_run;
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog well beyond the roughly 80 cycles the tests need
    initial begin
        #20000;
        n_mismatch++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        for (int k = 0; k < 4; k++)
            rd_reg(`TOMC_OFF_FUNC + k, rv[31-8*k -: 8]);
        rd_reg(20'h00000, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(`TOMC_OFF_FUNC, 8'(i));
            #1 chk({dc, rs, cp}, {i == 0, i == 1, i > 1}, "mode");
        end
        for (int i = 2; i < 4; i++) begin
            wr_reg(`TOMC_OFF_FUNC, 8'(i));
            m0 <= 1;
            #1 chk(bt, i == 3, "xfer");
            @(posedge clk) m0 <= 0;
            e1 <= 1;
            #1 chk(bt, i == 2, "xfer");
            @(posedge clk) e1 <= 0;
        end
        wr_reg(`TOMC_OFF_FUNC, 8'hff);
        rd_reg(`TOMC_OFF_FUNC, 8'hcf);
        wr_reg(`TOMC_OFF_FUNC, 8'hc0);
        #1 chk(xc, 1, "xclk");
        wr_reg(`TOMC_OFF_ODIS, 8'hfd);
        wr_reg(`TOMC_OFF_FUNC, 8'h40);
        #1 chk(xc, 0, "xclk");
        wr_reg(`TOMC_OFF_FUNC, 8'h80);
        wr_reg(`TOMC_OFF_ODIS, 8'h0f);
        wr_reg(`TOMC_OFF_INIT, 8'ha5);
        @(posedge clk);
        #1 chk(poe, 8'hf0, "oe");
        chk(po & poe, 8'ha0, "init");
        wr_reg(`TOMC_OFF_CUT, 8'h7f);
        @(posedge clk);
        #1 chk(ca, 1, "flag");
        chk({pad[5], poe[5:4], po[4]}, 8'h0a, "cut");
        rd_reg(`TOMC_OFF_CUT, 8'h01);
        @(posedge clk) run0 <= 1;
        wr_reg(`TOMC_OFF_CUT, 8'h00);
        rd_reg(`TOMC_OFF_CUT, 8'h01);
        @(posedge clk) run0 <= 0;
        wr_reg(`TOMC_OFF_CUT, 8'h00);
        rd_reg(`TOMC_OFF_CUT, 8'h00);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) pin_n <= 0;
            @(posedge clk) pin_n <= 1;
            rd_reg(`TOMC_OFF_CUT, k ? 8'h81 : 8'h00);
            wr_reg(`TOMC_OFF_CUT, 8'h80);
        end
        @(posedge clk) evl <= 1;
        @(posedge clk) evl <= 0;
        rd_reg(`TOMC_OFF_CUT, 8'h81);
        complete_run;
    end
endmodule
`default_nettype wire
